//--- src/usb_endpoint_control_status.sv
// Control and status logic of one full-speed USB device endpoint
`timescale 1ns/1ps
`include "ep_csr_defines.svh"

module usb_endpoint_control_status (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic tok_setup_i,
  input wire logic tok_out_i,
  input wire logic tok_in_i,
  input wire logic host_ack_i,
  input wire logic rx_pid_i,
  input wire logic rx_crc_ok_i,
  input wire logic [`EP_LEN_W-1:0] rx_len_i,
  output logic hs_valid_o,
  output ep_csr_pkg::handshake_e hs_code_o,
  output logic tx_send_o,
  output logic tx_pid_o,
  output logic rx_store_o,
  output logic rx_bank_o,
  output logic ep_irq_o
);

  typedef struct packed {
    ep_csr_pkg::endpoint_kind_e kind;
    logic active;
    logic dir;
    logic halt;
    logic armed;
    logic wait_ack;
    logic [`EP_LEN_W-1:0] len;
    logic [31:0] rdata;
    logic hs_valid;
    ep_csr_pkg::handshake_e hs_code;
    logic tx_send;
    logic tx_pid;
    logic rx_store;
    logic rx_bank;
    logic irq;
  } core_s;

  core_s st_q;
  core_s st_d;

  ep_core_if ev ();

  logic [`EP_FL_COUNT-1:0] fl_set;
  logic [`EP_FL_COUNT-1:0] fl_clr;
  ep_csr_pkg::toggle_op_e tg_op;
  logic csr_hit;
  logic ep_on;
  logic is_ctrl;
  logic bank0_free;
  logic bank1_free;
  logic any_free;
  logic use_bank1;
  logic exp_pid;
  logic [31:0] csr_rd;
  logic out_ok;
  logic in_ok;

  function automatic logic kind_iso(input ep_csr_pkg::endpoint_kind_e k);
    return (k == ep_csr_pkg::KIND_ISO_OUT) || (k == ep_csr_pkg::KIND_ISO_IN);
  endfunction

  function automatic logic kind_out(input ep_csr_pkg::endpoint_kind_e k);
    return (k == ep_csr_pkg::KIND_ISO_OUT) || (k == ep_csr_pkg::KIND_BULK_OUT) ||
           (k == ep_csr_pkg::KIND_INT_OUT);
  endfunction

  function automatic logic kind_in(input ep_csr_pkg::endpoint_kind_e k);
    return (k == ep_csr_pkg::KIND_ISO_IN) || (k == ep_csr_pkg::KIND_BULK_IN) ||
           (k == ep_csr_pkg::KIND_INT_IN);
  endfunction

  // Flags clear where firmware writes zero; a one leaves them as they are
  function automatic logic [`EP_FL_COUNT-1:0] clear_mask(input logic [31:0] w);
    logic [`EP_FL_COUNT-1:0] m;
    m[`EP_FL_IN_DONE] = ~w[`EP_BIT_IN_DONE];
    m[`EP_FL_BANK0] = ~w[`EP_BIT_BANK0];
    m[`EP_FL_SETUP] = ~w[`EP_BIT_SETUP];
    m[`EP_FL_ERR3] = ~w[`EP_BIT_ERR3];
    m[`EP_FL_BANK1] = ~w[`EP_BIT_BANK1];
    return m;
  endfunction

  // Status stage always carries DATA1, whatever the toggle holds
  function automatic logic stage_pid(input logic ctrl, input logic status, input logic tg);
    return (ctrl && status) ? 1'b1 : tg;
  endfunction

  ep_flag_bank u_flags (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ev(ev.bank)
  );

  ep_toggle_unit u_parity (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ev(ev.parity)
  );

  assign ev.flag_set = fl_set;
  assign ev.flag_clr = fl_clr;
  assign ev.tg_op = tg_op;

  assign csr_hit = (reg_addr_i == `EP_CSR_ADDR);
  assign is_ctrl = (st_q.kind == ep_csr_pkg::KIND_CTRL);
  // Control endpoints ignore the stored enable bit
  assign ep_on = is_ctrl | st_q.active;
  assign bank0_free = ~ev.flags[`EP_FL_BANK0];
  // Bank 1 only serves ping-pong endpoints; control never uses it
  assign bank1_free = `EP_PING_PONG & ~is_ctrl & ~ev.flags[`EP_FL_BANK1];
  assign any_free = bank0_free | bank1_free;
  assign use_bank1 = ~bank0_free;
  // An OUT against direction 1 is the status stage, which always carries DATA1
  assign exp_pid = stage_pid(is_ctrl, st_q.dir, ev.toggle);
  // A disabled endpoint or a token against its kind gets no answer at all
  assign out_ok = ep_on & (is_ctrl | kind_out(st_q.kind));
  assign in_ok = ep_on & (is_ctrl | kind_in(st_q.kind));

  always_comb begin
    csr_rd = 32'h0000_0000;
    csr_rd[`EP_BIT_IN_DONE] = ev.flags[`EP_FL_IN_DONE];
    csr_rd[`EP_BIT_BANK0] = ev.flags[`EP_FL_BANK0];
    csr_rd[`EP_BIT_SETUP] = ev.flags[`EP_FL_SETUP];
    csr_rd[`EP_BIT_ERR3] = ev.flags[`EP_FL_ERR3];
    csr_rd[`EP_BIT_ARMED] = st_q.armed;
    csr_rd[`EP_BIT_HALT] = st_q.halt;
    csr_rd[`EP_BIT_BANK1] = ev.flags[`EP_FL_BANK1];
    csr_rd[`EP_BIT_DIR] = st_q.dir;
    csr_rd[`EP_KIND_MSB:`EP_KIND_LSB] = st_q.kind;
    csr_rd[`EP_BIT_TOGGLE] = ev.toggle;
    csr_rd[`EP_BIT_ACTIVE] = ep_on;
    csr_rd[`EP_LEN_MSB:`EP_LEN_LSB] = st_q.len;
  end

  always_comb begin
    st_d = st_q;
    fl_set = '0;
    fl_clr = '0;
    tg_op = ep_csr_pkg::TG_HOLD;
    st_d.hs_valid = 1'b0;
    st_d.hs_code = ep_csr_pkg::HS_NONE;
    st_d.tx_send = 1'b0;
    st_d.rx_store = 1'b0;
    st_d.rdata = 32'h0000_0000;
    st_d.irq = |ev.flags;
    if (tok_setup_i || tok_out_i || tok_in_i) begin
      st_d.wait_ack = 1'b0;
    end

    if (tok_setup_i && is_ctrl) begin
      fl_set[`EP_FL_SETUP] = 1'b1;
      st_d.len = rx_len_i;
      // The setup is DATA0, so the first data stage packet is DATA1
      tg_op = ep_csr_pkg::TG_SET;
      st_d.hs_valid = 1'b1;
      st_d.hs_code = ep_csr_pkg::HS_ACK;
    end else if (tok_out_i && out_ok) begin
      if (st_q.halt) begin
        st_d.hs_valid = 1'b1;
        st_d.hs_code = ep_csr_pkg::HS_STALL;
        fl_set[`EP_FL_ERR3] = ~kind_iso(st_q.kind);
      end else if (ev.flags[`EP_FL_SETUP]) begin
        st_d.hs_valid = 1'b1;
        st_d.hs_code = ep_csr_pkg::HS_NAK;
      end else if (kind_iso(st_q.kind)) begin
        // Isochronous data is kept even when corrupt; the fault flag tells firmware
        if (any_free) begin
          st_d.rx_store = 1'b1;
          st_d.rx_bank = use_bank1;
          st_d.len = rx_len_i;
          fl_set[`EP_FL_BANK0] = ~use_bank1;
          fl_set[`EP_FL_BANK1] = use_bank1;
          fl_set[`EP_FL_ERR3] = ~rx_crc_ok_i;
        end
      end else if (!rx_crc_ok_i) begin
        // A corrupt packet gets no answer so the host retries it
        st_d.hs_valid = 1'b0;
      end else if (!any_free) begin
        st_d.hs_valid = 1'b1;
        st_d.hs_code = ep_csr_pkg::HS_NAK;
      end else if (rx_pid_i != exp_pid) begin
        // Repeat of a packet whose ACK was lost: acknowledge, do not store
        st_d.hs_valid = 1'b1;
        st_d.hs_code = ep_csr_pkg::HS_ACK;
      end else begin
        st_d.rx_store = 1'b1;
        st_d.rx_bank = use_bank1;
        st_d.len = rx_len_i;
        fl_set[`EP_FL_BANK0] = ~use_bank1;
        fl_set[`EP_FL_BANK1] = use_bank1;
        tg_op = ep_csr_pkg::TG_FLIP;
        st_d.hs_valid = 1'b1;
        st_d.hs_code = ep_csr_pkg::HS_ACK;
      end
    end else if (tok_in_i && in_ok) begin
      if (st_q.halt) begin
        st_d.hs_valid = 1'b1;
        st_d.hs_code = ep_csr_pkg::HS_STALL;
        fl_set[`EP_FL_ERR3] = ~kind_iso(st_q.kind);
      end else if (st_q.armed) begin
        st_d.tx_send = 1'b1;
        // IN against direction 0 is the status stage, always DATA1
        st_d.tx_pid = stage_pid(is_ctrl, !st_q.dir, ev.toggle);
        st_d.armed = 1'b0;
        if (kind_iso(st_q.kind)) begin
          fl_set[`EP_FL_IN_DONE] = 1'b1;
        end else begin
          st_d.wait_ack = 1'b1;
        end
      end else if (!kind_iso(st_q.kind)) begin
        st_d.hs_valid = 1'b1;
        st_d.hs_code = ep_csr_pkg::HS_NAK;
      end
    end

    if (host_ack_i && st_q.wait_ack) begin
      st_d.wait_ack = 1'b0;
      fl_set[`EP_FL_IN_DONE] = 1'b1;
      tg_op = ep_csr_pkg::TG_FLIP;
    end

    if (reg_wr_i && csr_hit) begin
      fl_clr = clear_mask(reg_wdata_i);
      st_d.kind = ep_csr_pkg::endpoint_kind_e'(reg_wdata_i[`EP_KIND_MSB:`EP_KIND_LSB]);
      if (!is_ctrl) begin
        st_d.active = reg_wdata_i[`EP_BIT_ACTIVE];
      end
      st_d.dir = reg_wdata_i[`EP_BIT_DIR];
      st_d.halt = reg_wdata_i[`EP_BIT_HALT];
      // Firmware write wins over the clear by a send in the same cycle
      st_d.armed = reg_wdata_i[`EP_BIT_ARMED];
    end

    if (reg_rd_i && csr_hit) begin
      st_d.rdata = csr_rd;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q.kind <= ep_csr_pkg::endpoint_kind_e'(`EP_KIND_RESET);
      st_q.active <= `EP_ACTIVE_RESET;
      st_q.dir <= `EP_DIR_RESET;
      st_q.halt <= `EP_HALT_RESET;
      st_q.armed <= `EP_ARMED_RESET;
      st_q.wait_ack <= 1'b0;
      st_q.len <= '0;
      st_q.rdata <= 32'h0000_0000;
      st_q.hs_valid <= 1'b0;
      // The handshake code rests at its none value, not at zero
      st_q.hs_code <= ep_csr_pkg::HS_NONE;
      st_q.tx_send <= 1'b0;
      st_q.tx_pid <= 1'b0;
      st_q.rx_store <= 1'b0;
      st_q.rx_bank <= 1'b0;
      st_q.irq <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;
  assign hs_valid_o = st_q.hs_valid;
  assign hs_code_o = st_q.hs_code;
  assign tx_send_o = st_q.tx_send;
  assign tx_pid_o = st_q.tx_pid;
  assign rx_store_o = st_q.rx_store;
  assign rx_bank_o = st_q.rx_bank;
  assign ep_irq_o = st_q.irq;

endmodule

//--- src/ep_csr_defines.svh
// Offsets, field positions and reset values of the endpoint control/status register
`ifndef EP_CSR_DEFINES_SVH
`define EP_CSR_DEFINES_SVH

`define EP_CSR_ADDR 32'hf803c030

`define EP_BIT_IN_DONE 0
`define EP_BIT_BANK0 1
`define EP_BIT_SETUP 2
`define EP_BIT_ERR3 3
`define EP_BIT_ARMED 4
`define EP_BIT_HALT 5
`define EP_BIT_BANK1 6
`define EP_BIT_DIR 7
`define EP_KIND_LSB 8
`define EP_KIND_MSB 10
`define EP_BIT_TOGGLE 11
`define EP_BIT_ACTIVE 15
`define EP_LEN_LSB 16
`define EP_LEN_MSB 26
`define EP_LEN_W 11

`define EP_FL_IN_DONE 0
`define EP_FL_BANK0 1
`define EP_FL_SETUP 2
`define EP_FL_ERR3 3
`define EP_FL_BANK1 4
`define EP_FL_COUNT 5

`define EP_KIND_RESET 3'h0
`define EP_ACTIVE_RESET 1'b0
`define EP_DIR_RESET 1'b0
`define EP_HALT_RESET 1'b0
`define EP_ARMED_RESET 1'b0
`define EP_TOGGLE_RESET 1'b0
`define EP_FLAGS_RESET 5'h00
`define EP_PING_PONG 1'b1

`endif

//--- src/ep_csr_pkg.sv
// Types shared by the endpoint control/status logic
package ep_csr_pkg;

  typedef enum logic [2:0] {
    KIND_CTRL = 3'b000,
    KIND_ISO_OUT = 3'b001,
    KIND_BULK_OUT = 3'b010,
    KIND_INT_OUT = 3'b011,
    KIND_RSVD = 3'b100,
    KIND_ISO_IN = 3'b101,
    KIND_BULK_IN = 3'b110,
    KIND_INT_IN = 3'b111
  } endpoint_kind_e;

  typedef enum logic [1:0] {
    HS_ACK = 2'b00,
    HS_NAK = 2'b01,
    HS_STALL = 2'b10,
    HS_NONE = 2'b11
  } handshake_e;

  typedef enum logic [1:0] {
    TG_HOLD = 2'b00,
    TG_CLEAR = 2'b01,
    TG_SET = 2'b10,
    TG_FLIP = 2'b11
  } toggle_op_e;

endpackage

//--- src/ep_core_if.sv
// Carrier between the endpoint core, its flag bank and its toggle unit
`timescale 1ns/1ps
`include "ep_csr_defines.svh"

interface ep_core_if;
  logic [`EP_FL_COUNT-1:0] flag_set;
  logic [`EP_FL_COUNT-1:0] flag_clr;
  logic [`EP_FL_COUNT-1:0] flags;
  ep_csr_pkg::toggle_op_e tg_op;
  logic toggle;

  modport core (
    output flag_set,
    output flag_clr,
    output tg_op,
    input flags,
    input toggle
  );

  modport bank (
    input flag_set,
    input flag_clr,
    output flags
  );

  modport parity (
    input tg_op,
    output toggle
  );
endinterface

//--- src/ep_flag_bank.sv
// Sticky status flags: set by the USB side, cleared by writing zero
`timescale 1ns/1ps
`include "ep_csr_defines.svh"

module ep_flag_bank (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  ep_core_if.bank ev
);

  typedef struct packed {
    logic [`EP_FL_COUNT-1:0] flag;
  } bank_s;

  bank_s st_q;
  bank_s st_d;
  logic [`EP_FL_COUNT-1:0] nxt;

  // Set beats clear so an event landing on a firmware clear is never lost
  genvar gi;
  generate
    for (gi = 0; gi < `EP_FL_COUNT; gi = gi + 1) begin : g_flag
      assign nxt[gi] = ev.flag_set[gi] | (st_q.flag[gi] & ~ev.flag_clr[gi]);
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    st_d.flag = nxt;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q.flag <= `EP_FLAGS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ev.flags = st_q.flag;

endmodule

//--- src/ep_toggle_unit.sv
// DATA0/DATA1 parity of the endpoint
`timescale 1ns/1ps
`include "ep_csr_defines.svh"

module ep_toggle_unit (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  ep_core_if.parity ev
);

  typedef struct packed {
    logic toggle;
  } parity_s;

  parity_s st_q;
  parity_s st_d;

  always_comb begin
    st_d = st_q;
    case (ev.tg_op)
      ep_csr_pkg::TG_HOLD: st_d.toggle = st_q.toggle;
      ep_csr_pkg::TG_CLEAR: st_d.toggle = 1'b0;
      ep_csr_pkg::TG_SET: st_d.toggle = 1'b1;
      ep_csr_pkg::TG_FLIP: st_d.toggle = ~st_q.toggle;
      default: st_d.toggle = st_q.toggle;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q.toggle <= `EP_TOGGLE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ev.toggle = st_q.toggle;

endmodule

//--- dv/usb_ep_asserts.sv
// Port-level checks of the endpoint control/status block
`timescale 1ns/1ps
`include "ep_csr_defines.svh"
module usb_ep_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic tok_setup_i,
  input wire logic tok_out_i,
  input wire logic tok_in_i,
  input wire logic host_ack_i,
  input wire logic hs_valid_o,
  input wire ep_csr_pkg::handshake_e hs_code_o,
  input wire logic tx_send_o,
  input wire logic tx_pid_o,
  input wire logic rx_store_o,
  input wire logic rx_bank_o,
  input wire logic ep_irq_o
);
  logic tok_any;
  assign tok_any = tok_setup_i | tok_out_i | tok_in_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  AST_HS_CAUSE: assert property (hs_valid_o |-> $past(tok_any))
    else $error("handshake without token");
  AST_SEND_CAUSE: assert property (tx_send_o |-> $past(tok_in_i))
    else $error("send without in token");
  AST_STORE_CAUSE: assert property (rx_store_o |-> $past(tok_out_i))
    else $error("store without out token");
  AST_STALL_ONLY: assert property (hs_valid_o && hs_code_o == ep_csr_pkg::HS_STALL
    |-> !tx_send_o && !rx_store_o) else $error("stall with data movement");
  AST_SETUP_ACK: assert property ($past(tok_setup_i) && hs_valid_o
    |-> hs_code_o == ep_csr_pkg::HS_ACK ##1 ep_irq_o) else $error("setup not acked");
  AST_STORE_ACK: assert property (rx_store_o && hs_valid_o
    |-> hs_code_o == ep_csr_pkg::HS_ACK) else $error("store without ack");
  AST_IRQ_CAUSE: assert property ($rose(ep_irq_o) |-> $past(tok_any | host_ack_i, 2))
    else $error("irq rose without event");
  AST_IRQ_CLEAR: assert property (reg_wr_i && reg_addr_i == `EP_CSR_ADDR
    && (reg_wdata_i & 32'h4f) == 32'h0 && !(tok_any | host_ack_i) |-> ##2 !ep_irq_o)
    else $error("irq kept after clear");
  AST_PID_HOLD: assert property (!tx_send_o |-> $stable(tx_pid_o))
    else $error("pid moved without send");
  AST_BANK_HOLD: assert property (!rx_store_o |-> $stable(rx_bank_o))
    else $error("bank moved without store");
  cover property (hs_valid_o && hs_code_o == ep_csr_pkg::HS_STALL);
  cover property (tx_send_o);
  cover property (rx_store_o && rx_bank_o);
endmodule

bind usb_endpoint_control_status usb_ep_checker i_usb_ep_checker (.clk_i, .sys_rst_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tok_setup_i, .tok_out_i,
  .tok_in_i, .host_ack_i, .hs_valid_o, .hs_code_o, .tx_send_o, .tx_pid_o, .rx_store_o,
  .rx_bank_o, .ep_irq_o);

//--- dv/usb_host_model.sv
// Host-side token source; released qualifiers show inverted values
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clk_i,
  input wire logic hs_valid_i,
  input wire ep_csr_pkg::handshake_e hs_code_i,
  output logic tok_setup_o,
  output logic tok_out_o,
  output logic tok_in_o,
  output logic host_ack_o,
  output logic pid_o,
  output logic crc_ok_o,
  output logic [10:0] len_o
);
  ep_csr_pkg::handshake_e got;
  initial begin
    {tok_setup_o, tok_out_o, tok_in_o, host_ack_o, pid_o, crc_ok_o} = 6'h0;
    len_o = 11'h0;
  end
  // Kind 0 setup, 1 out, 2 in, 3 ack
  task automatic send(input logic [1:0] k, input logic p, input logic c,
    input logic [10:0] n);
    @(posedge clk_i);
    {tok_setup_o, tok_out_o, tok_in_o, host_ack_o} <= 4'h8 >> k;
    {pid_o, crc_ok_o, len_o} <= {p, c, n};
    @(posedge clk_i);
    {tok_setup_o, tok_out_o, tok_in_o, host_ack_o} <= 4'h0;
    {pid_o, crc_ok_o, len_o} <= ~{p, c, n};
    #1;
    got = hs_valid_i ? hs_code_i : ep_csr_pkg::HS_NONE;
  endtask
endmodule

//--- dv/tb_usb_endpoint_control_status.sv
// Self-checking bench for the endpoint control/status block
`timescale 1ns/1ps
`include "ep_csr_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module tb_usb_endpoint_control_status;
  localparam logic [31:0] CSR = `EP_CSR_ADDR;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [31:0] reg_addr_i = 32'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic tok_setup, tok_out, tok_in, host_ack, rx_pid, rx_crc_ok;
  logic [`EP_LEN_W-1:0] rx_len;
  logic hs_valid_o, tx_send_o, tx_pid_o, rx_store_o, rx_bank_o, ep_irq_o;
  ep_csr_pkg::handshake_e hs_code_o;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #10 clk_i = ~clk_i;
  usb_endpoint_control_status i_usb_endpoint_control_status (.clk_i, .sys_rst_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tok_setup_i(tok_setup),
    .tok_out_i(tok_out), .tok_in_i(tok_in), .host_ack_i(host_ack), .rx_pid_i(rx_pid),
    .rx_crc_ok_i(rx_crc_ok), .rx_len_i(rx_len), .hs_valid_o, .hs_code_o, .tx_send_o,
    .tx_pid_o, .rx_store_o, .rx_bank_o, .ep_irq_o);
  usb_host_model i_usb_host_model (.clk_i, .hs_valid_i(hs_valid_o), .hs_code_i(hs_code_o),
    .tok_setup_o(tok_setup), .tok_out_o(tok_out), .tok_in_o(tok_in), .host_ack_o(host_ack),
    .pid_o(rx_pid), .crc_ok_o(rx_crc_ok), .len_o(rx_len));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic wr(input logic [31:0] v);
    @(posedge clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, CSR, v};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask
  task automatic ev(input logic [1:0] k, input logic p, input logic c, input logic [10:0] n,
    input ep_csr_pkg::handshake_e e);
    i_usb_host_model.send(k, p, c, n);
    `CHK(i_usb_host_model.got, e)
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(CSR, 32'h0000_8000);
    rd(32'h0, 32'h0);
    wr(32'h0000_00cf);
    rd(CSR, 32'h0000_8080);
    $display("register test done");
    ev(2'd0, 1'b0, 1'b1, 11'd8, ep_csr_pkg::HS_ACK);
    rd(CSR, 32'h0008_8884);
    `CHK(ep_irq_o, 1'b1)
    ev(2'd1, 1'b1, 1'b1, 11'd8, ep_csr_pkg::HS_NAK);
    wr(32'h0000_00db);
    ev(2'd2, 1'b0, 1'b1, 11'd0, ep_csr_pkg::HS_NONE);
    `CHK({tx_send_o, tx_pid_o}, 2'b11)
    rd(CSR, 32'h0008_8880);
    ev(2'd3, 1'b0, 1'b1, 11'd0, ep_csr_pkg::HS_NONE);
    rd(CSR, 32'h0008_8081);
    ev(2'd1, 1'b1, 1'b1, 11'd0, ep_csr_pkg::HS_ACK);
    `CHK({rx_store_o, rx_bank_o}, 2'b10)
    rd(CSR, 32'h0000_8883);
    wr(32'h0000_0080);
    repeat (3) @(posedge clk_i);
    rd(CSR, 32'h0000_8880);
    `CHK(ep_irq_o, 1'b0)
    $display("control test done");
    wr(32'h0000_8200);
    // The enable bit is only stored once the kind is no longer control
    wr(32'h0000_8200);
    ev(2'd1, 1'b1, 1'b1, 11'd5, ep_csr_pkg::HS_ACK);
    ev(2'd1, 1'b0, 1'b1, 11'd6, ep_csr_pkg::HS_ACK);
    `CHK({rx_store_o, rx_bank_o}, 2'b11)
    ev(2'd1, 1'b1, 1'b1, 11'd7, ep_csr_pkg::HS_NAK);
    rd(CSR, 32'h0006_8a42);
    wr(32'h0000_024f);
    ev(2'd1, 1'b1, 1'b1, 11'd3, ep_csr_pkg::HS_NONE);
    rd(CSR, 32'h0006_0a42);
    wr(32'h0000_826f);
    ev(2'd1, 1'b1, 1'b1, 11'd1, ep_csr_pkg::HS_STALL);
    rd(CSR, 32'h0006_8a6a);
    wr(32'h0000_8247);
    rd(CSR, 32'h0006_8a42);
    $display("bulk test done");
    wr(32'h0000_8100);
    ev(2'd1, 1'b0, 1'b0, 11'd4, ep_csr_pkg::HS_NONE);
    rd(CSR, 32'h0004_890a);
    // Length of the last stored packet is kept across kind changes
    for (int k = 0; k < 8; k++) begin
      wr({16'h0, 1'b1, 4'h0, k[2:0], 8'h0});
      rd(CSR, {16'h0004, 1'b1, 3'h0, 1'b1, k[2:0], 8'h0});
    end
    $display("kind test done");
    end_sim();
  end
endmodule
